// ---- core/uart_lms_defines.svh ----
/*
 * Register offsets, field positions, reset values and timing counts of the
 * line and modem status block. Assumes an eight-entry parallel register map.
 */
`ifndef UART_LMS_DEFINES_SVH
`define UART_LMS_DEFINES_SVH
`define ULMS_ADR_RXD 3'h0
`define ULMS_ADR_MCR 3'h4
`define ULMS_ADR_LSR 3'h5
`define ULMS_ADR_MSR 3'h6
`define ULMS_MCR_DTR 0
`define ULMS_MCR_RTS 1
`define ULMS_MCR_OUT1 2
`define ULMS_MCR_OUT2 3
`define ULMS_MCR_LOOP 4
`define ULMS_MCR_XANY 5
`define ULMS_MCR_IR 6
`define ULMS_MCR_PRESC 7
`define ULMS_FW_TXDIS 4
`define ULMS_MCR_RST 8'h00
`define ULMS_FW_RST 8'h00
`define ULMS_PIN_RST 5'h1f
`define ULMS_RXF_DEPTH 16
`define ULMS_PRESC_LAST 2'h3
`define ULMS_IR_PULSE 4'h3
`define ULMS_IR_HOLD 5'h10
`endif

// ---- core/uart_lms_pkg.sv ----
/*
 * Types of the line and modem status block.
 * Assumes the receiver core delivers one character record per completed frame.
 */
package uart_lms_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic pe;
        logic fe;
        logic bi;
        logic flow;
    } rx_char_t;
    typedef struct packed {
        logic [7:0] data;
        logic pe;
        logic fe;
        logic bi;
    } rx_entry_t;
    typedef enum logic [1:0] {
        RXS_NORMAL = 2'b01,
        RXS_BREAK = 2'b10
    } rx_state_t;
endpackage

// ---- core/uart_line_modem_status.sv ----
/*
 * Line status, modem status and upper modem control of a small-FIFO UART.
 * Assumes one-cycle CS/RD/WR strobes synchronous to CLK_SYS, a receiver core
 * handing over finished characters, a transmitter core and a baud generator.
 */
// Operation
// - xon-any: any received char resumes transmitter; flow chars not stored
// - infrared bit routes tx/rx through ir codec; ir tx low when idle
// - prescaler bit feeds baud generator clock divided by one or four
// - xon-any, infrared and prescaler bits act only with enhanced enable
// - line interrupt: overrun at once, parity/framing errors when char at head, break at head or while break state held
// - data ready while any received char is held
// - full buffer on new char sets overrun, char dropped, stored data kept
// - parity error flag belongs to the head character
// - framing error flag belongs to the head character
// - break loads one char and holds indication until line high
// - holding empty set on move to shifter, cleared on host load; in fifo mode follows tx fifo empty
// - transmitter empty only when holding and shift register both empty
// - fifo error flag while any char in the fifo carries an error tag; two-entry buffer not counted
// - cts, dsr, cd changes set deltas and modem interrupt request
// - ring delta only on ring input low to high
// - auto cts: high cts pin stops transmitter, low resumes
// - cts status inverse of pin, or rts bit in loopback
// - dsr status inverse of pin, or dtr bit in loopback
// - ring status inverse of pin, or control bit 2 in loopback
// - carrier status inverse of pin, or control bit 3 in loopback
// - writes to status address load feature register, low nibble ignored
// - loopback bit selects internal loopback, status mirrors control bits
// - feature bit 4 disables the transmitter, only with enhanced enable
`timescale 1ns/1ps
`default_nettype none
`include "uart_lms_defines.svh"

module uart_line_modem_status (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CS,
    input wire logic RD,
    input wire logic WR,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] DIN,
    output logic [7:0] DOUT,
    input wire logic ENH_FUNC_EN,
    input wire logic LS_INT_EN,
    input wire logic MS_INT_EN,
    input wire logic AUTO_CTS_EN,
    input wire logic SW_FLOW_EN,
    input wire logic FIFO_MODE,
    input wire uart_lms_pkg::rx_char_t RX_CHAR,
    output logic RX_CHAR_RDY,
    output logic RX_SER,
    input wire logic TICK16,
    output logic BRG_CLK_EN,
    input wire logic TX_SER,
    input wire logic TX_SHIFT_LOAD,
    input wire logic TSR_EMPTY,
    input wire logic TX_FIFO_EMPTY,
    output logic TX_HALT,
    output logic TX_RESUME,
    output logic IR_MODE,
    input wire logic RXD,
    output logic TXD,
    input wire logic CTS_N,
    input wire logic DSR_N,
    input wire logic RING_INDICATOR_N,
    input wire logic CARRIER_DETECT_N,
    output logic DTR_N,
    output logic RTS_N,
    output logic LSR_INT_REQ,
    output logic MS_INT_REQ
);
    import uart_lms_pkg::*;

    function automatic logic tagged_err(input rx_entry_t e);
        tagged_err = e.pe | e.fe | e.bi;
    endfunction

    // ==========================================================
    // pin synchronisers
    wire [4:0] pin_raw = {CARRIER_DETECT_N, RING_INDICATOR_N, DSR_N, CTS_N, RXD};
    logic [4:0] filt_ff;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            logic [2:0] sync_ff;
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    sync_ff <= 3'h7;
                    filt_ff[gi] <= 1'b1;
                end else begin
                    sync_ff <= {sync_ff[1:0], pin_raw[gi]};
                    if (sync_ff[1] == sync_ff[2]) begin
                        filt_ff[gi] <= sync_ff[2];
                    end
                end
            end
        end
    endgenerate
    wire rxd_f = filt_ff[0];

    // ==========================================================
    // control registers
    logic [7:0] mcr_ff;
    logic [7:0] fw_ff;
    wire rd_hit = CS & RD;
    wire wr_hit = CS & WR;
    wire rd_rxd = rd_hit & (ADDR == `ULMS_ADR_RXD);
    wire rd_lsr = rd_hit & (ADDR == `ULMS_ADR_LSR);
    wire rd_msr = rd_hit & (ADDR == `ULMS_ADR_MSR);
    wire wr_thr = wr_hit & (ADDR == `ULMS_ADR_RXD);
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            mcr_ff <= `ULMS_MCR_RST;
            fw_ff <= `ULMS_FW_RST;
        end else begin
            if (wr_hit & (ADDR == `ULMS_ADR_MCR)) begin
                mcr_ff <= DIN;
            end
            if (wr_hit & (ADDR == `ULMS_ADR_MSR)) begin
                fw_ff <= {DIN[7:4], 4'h0};
            end
        end
    end
    wire lp = mcr_ff[`ULMS_MCR_LOOP];
    wire xany_eff = mcr_ff[`ULMS_MCR_XANY] & ENH_FUNC_EN;
    wire ir_eff = mcr_ff[`ULMS_MCR_IR] & ENH_FUNC_EN;
    wire presc_eff = mcr_ff[`ULMS_MCR_PRESC] & ENH_FUNC_EN;
    wire txdis_eff = fw_ff[`ULMS_FW_TXDIS] & ENH_FUNC_EN;
    assign IR_MODE = ir_eff;

    // ==========================================================
    // prescaler
    logic [1:0] presc_ff;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            presc_ff <= 2'h0;
        end else begin
            presc_ff <= presc_ff + 2'h1;
        end
    end
    assign BRG_CLK_EN = presc_eff ? (presc_ff == `ULMS_PRESC_LAST) : 1'b1;

    // ==========================================================
    // infrared codec and line routing
    logic [3:0] tick_ff;
    logic [4:0] hold_ff;
    logic txd_ff;
    wire ir_tx = ~TX_SER & (tick_ff < `ULMS_IR_PULSE);
    wire nxt_txd = lp ? ~ir_eff : (ir_eff ? ir_tx : TX_SER);
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            tick_ff <= 4'h0;
            hold_ff <= 5'h0;
            txd_ff <= 1'b1;
        end else begin
            if (TICK16) begin
                tick_ff <= tick_ff + 4'h1;
            end
            if (rxd_f) begin
                hold_ff <= `ULMS_IR_HOLD;
            end else if (TICK16 && hold_ff != 5'h0) begin
                hold_ff <= hold_ff - 5'h1;
            end
            txd_ff <= nxt_txd;
        end
    end
    wire ir_rx = (hold_ff == 5'h0);
    assign RX_SER = lp ? TX_SER : (ir_eff ? ir_rx : rxd_f);
    assign TXD = txd_ff;
    assign DTR_N = lp | ~mcr_ff[`ULMS_MCR_DTR];
    assign RTS_N = lp | ~mcr_ff[`ULMS_MCR_RTS];

    // ==========================================================
    // receive intake, two-entry buffer and fifo
    rx_state_t rxs_ff;
    rx_state_t nxt_rxs;
    rx_entry_t bf_mem [2];
    rx_entry_t rf_mem [`ULMS_RXF_DEPTH];
    logic [1:0] bf_cnt_ff;
    logic bf_wp_ff;
    logic bf_rp_ff;
    logic [4:0] rf_cnt_ff;
    logic [3:0] rf_wp_ff;
    logic [3:0] rf_rp_ff;
    logic [4:0] err_cnt_ff;
    logic ovr_ff;
    logic resume_ff;
    wire rx_entry_t in_e = '{data: RX_CHAR.data, pe: RX_CHAR.pe, fe: RX_CHAR.fe, bi: RX_CHAR.bi};
    wire keep_ch = RX_CHAR.valid & ~(RX_CHAR.flow & SW_FLOW_EN) & (rxs_ff != RXS_BREAK);
    wire bf_in_rdy = (bf_cnt_ff != 2'h2);
    wire bf_push = keep_ch & bf_in_rdy;
    wire ovr_set = keep_ch & ~bf_in_rdy;
    wire rf_full = (rf_cnt_ff == 5'(`ULMS_RXF_DEPTH));
    wire bf_pop = (bf_cnt_ff != 2'h0) & ~rf_full;
    wire rx_entry_t bf_head = bf_mem[bf_rp_ff];
    wire rx_entry_t head = rf_mem[rf_rp_ff];
    wire rf_nonempty = (rf_cnt_ff != 5'h0);
    wire rf_pop = rd_rxd & rf_nonempty;
    wire tag_in = bf_pop & tagged_err(bf_head);
    wire tag_out = rf_pop & tagged_err(head);
    assign RX_CHAR_RDY = bf_in_rdy;
    assign TX_RESUME = resume_ff;

    always_comb begin
        nxt_rxs = rxs_ff;
        case (rxs_ff)
            RXS_NORMAL: begin
                if (bf_push & RX_CHAR.bi) begin
                    nxt_rxs = RXS_BREAK;
                end
            end
            RXS_BREAK: begin
                if (RX_SER) begin
                    nxt_rxs = RXS_NORMAL;
                end
            end
            default: begin
                nxt_rxs = RXS_NORMAL;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rxs_ff <= RXS_NORMAL;
            bf_cnt_ff <= 2'h0;
            bf_wp_ff <= 1'b0;
            bf_rp_ff <= 1'b0;
            rf_cnt_ff <= 5'h0;
            rf_wp_ff <= 4'h0;
            rf_rp_ff <= 4'h0;
            err_cnt_ff <= 5'h0;
            ovr_ff <= 1'b0;
            resume_ff <= 1'b0;
        end else begin
            rxs_ff <= nxt_rxs;
            resume_ff <= xany_eff & RX_CHAR.valid;
            if (bf_push) begin
                bf_mem[bf_wp_ff] <= in_e;
                bf_wp_ff <= ~bf_wp_ff;
            end
            if (bf_pop) begin
                rf_mem[rf_wp_ff] <= bf_head;
                rf_wp_ff <= rf_wp_ff + 4'h1;
                bf_rp_ff <= ~bf_rp_ff;
            end
            if (rf_pop) begin
                rf_rp_ff <= rf_rp_ff + 4'h1;
            end
            bf_cnt_ff <= bf_cnt_ff + {1'b0, bf_push} - {1'b0, bf_pop};
            rf_cnt_ff <= rf_cnt_ff + {4'h0, bf_pop} - {4'h0, rf_pop};
            err_cnt_ff <= err_cnt_ff + {4'h0, tag_in} - {4'h0, tag_out};
            if (ovr_set) begin
                ovr_ff <= 1'b1;
            end else if (rd_lsr) begin
                ovr_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // transmit status
    logic thr_empty_ff;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            thr_empty_ff <= 1'b1;
        end else if (wr_thr) begin
            thr_empty_ff <= 1'b0;
        end else if (TX_SHIFT_LOAD) begin
            thr_empty_ff <= 1'b1;
        end
    end
    wire lsr_thre = FIFO_MODE ? TX_FIFO_EMPTY : thr_empty_ff;
    wire lsr_temt = lsr_thre & TSR_EMPTY;

    // ==========================================================
    // line status
    wire data_rdy = rf_nonempty | (bf_cnt_ff != 2'h0);
    wire head_pe = rf_nonempty & head.pe;
    wire head_fe = rf_nonempty & head.fe;
    wire head_bi = (rf_nonempty & head.bi) | (rxs_ff == RXS_BREAK);
    wire fifo_err = (err_cnt_ff != 5'h0);
    wire [7:0] line_status = {fifo_err, lsr_temt, lsr_thre, head_bi, head_fe, head_pe, ovr_ff, data_rdy};
    assign LSR_INT_REQ = LS_INT_EN & (ovr_ff | head_pe | head_fe | head_bi);

    // ==========================================================
    // modem status
    wire [3:0] st_pin = ~filt_ff[4:1];
    wire [3:0] st_lp = {mcr_ff[`ULMS_MCR_OUT2], mcr_ff[`ULMS_MCR_OUT1],
                        mcr_ff[`ULMS_MCR_DTR], mcr_ff[`ULMS_MCR_RTS]};
    wire [3:0] st_cur = lp ? st_lp : st_pin;
    logic [3:0] st_prev_ff;
    logic [3:0] dlt_ff;
    wire [3:0] chg = st_prev_ff ^ st_cur;
    wire [3:0] dlt_set = {chg[3], st_prev_ff[2] & ~st_cur[2], chg[1:0]};
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_prev_ff <= 4'h0;
            dlt_ff <= 4'h0;
        end else begin
            st_prev_ff <= st_cur;
            dlt_ff <= dlt_set | (rd_msr ? 4'h0 : dlt_ff);
        end
    end
    wire [7:0] modem_status = {st_cur, dlt_ff};
    assign MS_INT_REQ = MS_INT_EN & (dlt_ff != 4'h0);
    assign TX_HALT = txdis_eff | (AUTO_CTS_EN & ~st_cur[0]);

    // ==========================================================
    // read port
    logic [7:0] dout_ff;
    wire [7:0] rd_mux = (ADDR == `ULMS_ADR_RXD) ? (rf_nonempty ? head.data : 8'h00) :
                        (ADDR == `ULMS_ADR_MCR) ? mcr_ff :
                        (ADDR == `ULMS_ADR_LSR) ? line_status :
                        (ADDR == `ULMS_ADR_MSR) ? modem_status : 8'h00;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            dout_ff <= 8'h00;
        end else if (rd_hit) begin
            dout_ff <= rd_mux;
        end
    end
    assign DOUT = dout_ff;

    // ==========================================================
    // assertions
    a_ovr_set: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ovr_set |=> line_status[1])
        else $error("overrun not flagged");
    a_dr_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (rf_cnt_ff == 5'h1 && bf_cnt_ff == 2'h0 && rf_pop && !bf_push) |=> !line_status[0])
        else $error("data ready stuck after last read");
    a_presc_rate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (presc_eff && BRG_CLK_EN) |=> (!BRG_CLK_EN || !presc_eff)[*3])
        else $error("prescaler not dividing by four");
    a_ir_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (ir_eff && !lp && TX_SER) |=> !TXD)
        else $error("ir output high while idle");
    a_enh_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !ENH_FUNC_EN |-> !IR_MODE && BRG_CLK_EN ##1 !TX_RESUME)
        else $error("enhanced bit acted without enable");
    a_msr_loop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        lp |-> modem_status[7:4] == {mcr_ff[3], mcr_ff[2], mcr_ff[0], mcr_ff[1]})
        else $error("loopback status mismatch");
    a_ri_delta: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (!lp && $past(!lp) && $rose(filt_ff[3])) |=> dlt_ff[2])
        else $error("ring end not flagged");
    a_ri_nofall: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (!lp && $past(!lp) && $fell(filt_ff[3]) && !dlt_ff[2]) |=> !dlt_ff[2])
        else $error("ring delta on falling pin");
    a_err_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (err_cnt_ff == 5'h1 && tag_out && !tag_in) |=> !line_status[7])
        else $error("fifo error flag stuck");
    a_cts_halt: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (AUTO_CTS_EN && !lp && filt_ff[1]) |-> TX_HALT)
        else $error("transmitter not stopped by cts");
    a_lsr_irq: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(ovr_ff) && LS_INT_EN |-> LSR_INT_REQ)
        else $error("overrun interrupt late");
    a_temt_both: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (!TSR_EMPTY || !lsr_thre) |-> !line_status[6])
        else $error("transmitter empty while busy");
endmodule
`default_nettype wire

// ---- verification/remote_modem.sv ----
/*
 * Far-side modem model: drives the four modem pins and the serial line.
 * Assumes the bench changes req just after a clock edge; pins follow next edge.
 */
`timescale 1ns/1ps
`default_nettype none
module remote_modem (
    input wire logic clk,
    input wire logic [3:0] req,
    output logic cts_n,
    output logic dsr_n,
    output logic ring_n,
    output logic carrier_n,
    output wire logic rxd
);
    // ==========================================
    // modem pins, idle high
    initial begin
        {carrier_n, ring_n, dsr_n, cts_n} = 4'hf;
    end
    always @(posedge clk) begin
        cts_n <= ~req[0];
        {carrier_n, ring_n, dsr_n} <= ~req[3:1];
    end
    // line held at mark, no frames sent
    assign rxd = 1'b1;
endmodule
`default_nettype wire

// ---- verification/uart_line_modem_status_test.sv ----
/*
 * Self-checking bench for the line and modem status block.
 * Assumes the register map of the design header and a 50 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uart_lms_defines.svh"
module uart_line_modem_status_test;
    import uart_lms_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, cs = 1'b0, rd = 1'b0, wr = 1'b0;
    logic enh = 1'b0, auto_cts = 1'b0, sw_flow = 1'b0, fifo_mode = 1'b0;
    logic shift_load = 1'b0, tsr_empty = 1'b1, txf_empty = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] din = 8'h00;
    logic [3:0] mreq = 4'h0;
    rx_char_t rx_char = '0;
    wire logic [7:0] dout;
    wire logic rx_rdy, brg_en, tx_halt, tx_resume, ir_mode, txd, dtr_n, rts_n, ls_int, ms_int;
    wire logic cts_n, dsr_n, ring_n, cd_n, rxd;
    logic [7:0] v;
    int fail_count = 0;
    int total_checks = 0;

    always #10 clk_sys = ~clk_sys;

    remote_modem u_modem (.clk(clk_sys), .req(mreq), .cts_n(cts_n), .dsr_n(dsr_n),
        .ring_n(ring_n), .carrier_n(cd_n), .rxd(rxd));

    uart_line_modem_status u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS(cs), .RD(rd),
        .WR(wr), .ADDR(addr), .DIN(din), .DOUT(dout), .ENH_FUNC_EN(enh), .LS_INT_EN(1'b1),
        .MS_INT_EN(1'b1), .AUTO_CTS_EN(auto_cts), .SW_FLOW_EN(sw_flow), .FIFO_MODE(fifo_mode),
        .RX_CHAR(rx_char), .RX_CHAR_RDY(rx_rdy), .RX_SER(), .TICK16(1'b0),
        .BRG_CLK_EN(brg_en), .TX_SER(1'b1), .TX_SHIFT_LOAD(shift_load), .TSR_EMPTY(tsr_empty),
        .TX_FIFO_EMPTY(txf_empty), .TX_HALT(tx_halt), .TX_RESUME(tx_resume),
        .IR_MODE(ir_mode), .RXD(rxd), .TXD(txd), .CTS_N(cts_n), .DSR_N(dsr_n),
        .RING_INDICATOR_N(ring_n), .CARRIER_DETECT_N(cd_n), .DTR_N(dtr_n), .RTS_N(rts_n),
        .LSR_INT_REQ(ls_int), .MS_INT_REQ(ms_int));

    // ==========================================
    // shared tasks
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cs <= 1'b1;
        wr <= 1'b1;
        addr <= a;
        din <= d;
        @(posedge clk_sys);
        cs <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m,
            input string name);
        @(posedge clk_sys);
        cs <= 1'b1;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        cs <= 1'b0;
        rd <= 1'b0;
        #1;
        chk(name, exp, dout & m);
    endtask
    task automatic setm(input logic [3:0] r);
        @(posedge clk_sys);
        mreq <= r;
        cyc(8);
    endtask
    task automatic push(input logic [7:0] d, input logic pe, input logic fl, output logic res);
        @(posedge clk_sys);
        rx_char <= {1'b1, d, pe, 1'b0, 1'b0, fl};
        @(posedge clk_sys);
        rx_char.valid <= 1'b0;
        #1;
        res = tx_resume;
    endtask
    task automatic brg8(output logic [7:0] n);
        n = 8'h00;
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            n = n + {7'h0, brg_en};
        end
    endtask
    task automatic set_enh(input logic e);
        @(posedge clk_sys);
        enh <= e;
        cyc(2);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rchk(`ULMS_ADR_MSR, 8'h00, 8'hff, "msr_idle");
        rchk(`ULMS_ADR_MCR, `ULMS_MCR_RST, 8'hff, "mcr_reset");
        rchk(3'h1, 8'h00, 8'hff, "unmapped");
        chk("dtr_rts_idle", 8'h03, {6'h0, dtr_n, rts_n});
    endtask
    task automatic t_loop();
        wreg(`ULMS_ADR_MCR, 8'h1f);
        cyc(4);
        chk("loop_pins", 8'h03, {6'h0, dtr_n, rts_n});
        rchk(`ULMS_ADR_MSR, 8'hfb, 8'hff, "loop_on");
        rchk(`ULMS_ADR_MSR, 8'hf0, 8'hff, "loop_clr");
        wreg(`ULMS_ADR_MCR, 8'h10);
        cyc(4);
        rchk(`ULMS_ADR_MSR, 8'h0f, 8'hff, "loop_off");
        wreg(`ULMS_ADR_MCR, 8'h03);
        cyc(4);
        rchk(`ULMS_ADR_MSR, 8'h00, 8'hff, "normal_idle");
        chk("dtr_rts_on", 8'h00, {6'h0, dtr_n, rts_n});
    endtask
    task automatic t_pins();
        setm(4'h1);
        chk("ms_int", 8'h01, {7'h0, ms_int});
        rchk(`ULMS_ADR_MSR, 8'h11, 8'hff, "cts_low");
        setm(4'h5);
        rchk(`ULMS_ADR_MSR, 8'h50, 8'hff, "ring_on");
        setm(4'hf);
        rchk(`ULMS_ADR_MSR, 8'hfa, 8'hff, "dsr_cd");
        setm(4'hb);
        rchk(`ULMS_ADR_MSR, 8'hb4, 8'hff, "ring_end");
        setm(4'h0);
        rchk(`ULMS_ADR_MSR, 8'h0b, 8'hff, "all_idle");
    endtask
    task automatic t_halt();
        @(posedge clk_sys);
        auto_cts <= 1'b1;
        cyc(2);
        chk("cts_stop", 8'h01, {7'h0, tx_halt});
        setm(4'h1);
        chk("cts_go", 8'h00, {7'h0, tx_halt});
        auto_cts <= 1'b0;
        set_enh(1'b1);
        wreg(`ULMS_ADR_MSR, 8'h0f);
        cyc(2);
        chk("low_nibble", 8'h00, {7'h0, tx_halt});
        wreg(`ULMS_ADR_MSR, 8'h10);
        cyc(2);
        chk("tx_disable", 8'h01, {7'h0, tx_halt});
        set_enh(1'b0);
        chk("tx_dis_gate", 8'h00, {7'h0, tx_halt});
        wreg(`ULMS_ADR_MSR, 8'h00);
        setm(4'h0);
    endtask
    task automatic t_upper();
        wreg(`ULMS_ADR_MCR, 8'hc0);
        brg8(v);
        chk("div_gated", 8'h08, v);
        chk("ir_gated", 8'h01, {6'h0, ir_mode, txd});
        set_enh(1'b1);
        brg8(v);
        chk("div_four", 8'h02, v);
        chk("ir_idle", 8'h02, {6'h0, ir_mode, txd});
        rchk(`ULMS_ADR_RXD, 8'h00, 8'hff, "ir_flush");
        wreg(`ULMS_ADR_MCR, 8'h20);
        push(8'h41, 1'b0, 1'b0, v[0]);
        chk("resume_any", 8'h01, {7'h0, v[0]});
        @(posedge clk_sys);
        sw_flow <= 1'b1;
        push(8'h11, 1'b0, 1'b1, v[0]);
        chk("resume_flow", 8'h01, {7'h0, v[0]});
        rchk(`ULMS_ADR_RXD, 8'h41, 8'hff, "kept_char");
        rchk(`ULMS_ADR_LSR, 8'h00, 8'h01, "flow_dropped");
        sw_flow <= 1'b0;
        set_enh(1'b0);
        push(8'h42, 1'b0, 1'b0, v[0]);
        chk("resume_gated", 8'h00, {7'h0, v[0]});
        rchk(`ULMS_ADR_RXD, 8'h42, 8'hff, "gated_char");
        wreg(`ULMS_ADR_MCR, 8'h00);
    endtask
    task automatic t_rx();
        push(8'h5a, 1'b1, 1'b0, v[0]);
        cyc(2);
        chk("ls_int_pe", 8'h01, {7'h0, ls_int});
        rchk(`ULMS_ADR_LSR, 8'h85, 8'h9f, "pe_head");
        rchk(`ULMS_ADR_RXD, 8'h5a, 8'hff, "pe_data");
        rchk(`ULMS_ADR_LSR, 8'h00, 8'h9f, "rx_empty");
        for (int i = 0; i < 18; i++) push(8'(i), 1'b0, 1'b0, v[0]);
        cyc(2);
        chk("full_rdy", 8'h00, {7'h0, rx_rdy});
        push(8'hee, 1'b0, 1'b0, v[0]);
        cyc(2);
        chk("ls_int_oe", 8'h01, {7'h0, ls_int});
        rchk(`ULMS_ADR_LSR, 8'h03, 8'h9f, "overrun");
        for (int i = 0; i < 18; i++) rchk(`ULMS_ADR_RXD, 8'(i), 8'hff, "fifo_data");
        rchk(`ULMS_ADR_LSR, 8'h00, 8'h9f, "drained");
        @(posedge clk_sys);
        rx_char <= {1'b1, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0};
        @(posedge clk_sys);
        rx_char.valid <= 1'b0;
        cyc(2);
        rchk(`ULMS_ADR_LSR, 8'h99, 8'h9f, "brk_head");
        rchk(`ULMS_ADR_RXD, 8'h00, 8'hff, "brk_data");
        rchk(`ULMS_ADR_LSR, 8'h00, 8'h9f, "brk_gone");
    endtask
    task automatic t_tx();
        wreg(`ULMS_ADR_RXD, 8'h33);
        rchk(`ULMS_ADR_LSR, 8'h00, 8'h60, "thr_load");
        @(posedge clk_sys);
        shift_load <= 1'b1;
        tsr_empty <= 1'b0;
        @(posedge clk_sys);
        shift_load <= 1'b0;
        rchk(`ULMS_ADR_LSR, 8'h20, 8'h60, "tsr_busy");
        tsr_empty <= 1'b1;
        rchk(`ULMS_ADR_LSR, 8'h60, 8'h60, "tx_idle");
        fifo_mode <= 1'b1;
        txf_empty <= 1'b0;
        rchk(`ULMS_ADR_LSR, 8'h00, 8'h60, "txf_busy");
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_loop();
        t_pins();
        t_halt();
        t_upper();
        t_rx();
        t_tx();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
